// [sts_pkg.sv]
// Purpose: shared constants and types of the self-test supervisor
// Assumes: 125 MHz system clock, synchronous active-high reset
// Notes: offsets are byte addresses on the register bus
// Function
// - Sum the program memory and flag a failure when the sum differs from the stored reference.
// - A program memory failure turns off protection and control and latches the alarm.
// - A program memory failure report carries the socket of the failing chip.
// - The converter test fails on a slow or never-ending conversion and has no warning level.
// - A converter failure turns off protection only, reports, and closes the alarm.
// - The master offset check selects a grounded input, warns above 50 mV and fails above 75 mV.
// - A master offset failure gives a one second alarm pulse and leaves all functions on.
// - Both settings copies are compared at each run and any mismatch turns off protection and control.
// - A settings mismatch is reported and keeps the alarm latched.
// - A channel offset above 75 mV gives a one second alarm pulse and leaves all functions on.
// - A warning is reported but never touches the alarm or any function.
// - Every change of a test between normal, warning and failure is reported.
// - All tests run at power up and before new settings are applied.
// - A +5 V supply failure drops and blocks every output contact.
// - A +/-15 V supply failure turns off protection and leaves control on.
package sts_pkg;
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_STAT  = 8'h04;
  localparam logic [7:0]  ADDR_SOCK  = 8'h08;
  localparam logic [7:0]  ADDR_IST   = 8'h0c;
  localparam logic [7:0]  ADDR_IMSK  = 8'h10;
  localparam int          CTRL_NEWSET = 0;
  localparam int          CTRL_RUN    = 1;
  localparam int          STAT_BUSY   = 16;
  localparam int          STAT_PROT   = 17;
  localparam int          STAT_CTRL   = 18;
  localparam int          STAT_ALARM  = 19;
  localparam int          STAT_CONT   = 20;
  localparam int          IST_DONE    = 7;
  localparam logic [7:0]  IMSK_RESET  = 8'h00;
  localparam int          NTEST  = 7;
  localparam int          T_MEM  = 0;
  localparam int          T_ADC  = 1;
  localparam int          T_MOF  = 2;
  localparam int          T_CHAN = 3;
  localparam int          T_SET  = 4;
  localparam int          T_P5   = 5;
  localparam int          T_P15  = 6;
  localparam logic [1:0]  C_NORM = 2'h0;
  localparam logic [1:0]  C_WARN = 2'h1;
  localparam logic [1:0]  C_FAIL = 2'h2;
  // 50 mV and 75 mV, offsets arrive in whole millivolts
  localparam logic [7:0]  OFS_WARN_MV = 8'h32;
  localparam logic [7:0]  OFS_FAIL_MV = 8'h4b;
  localparam int          CLK_NS      = 8;
  // longest allowed conversion, plain default
  localparam int          ADC_LIMIT_NS = 2000;
  localparam int          ADC_CYC      = ADC_LIMIT_NS / CLK_NS;
  localparam int          PULSE_MS     = 1000;
  localparam int          PULSE_CYC    = PULSE_MS * 1000000 / CLK_NS;
  localparam int          CHECK_MS     = 1000;
  localparam int          PERIOD_CYC   = CHECK_MS * 1000000 / CLK_NS;
  localparam int          CNT_W        = 32;
  localparam logic [15:0] SUM_RESET    = 16'h0000;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_MEM  = 7'h02,
    ST_ADC  = 7'h04,
    ST_MOF  = 7'h08,
    ST_CHAN = 7'h10,
    ST_SET  = 7'h20,
    ST_DONE = 7'h40
  } sts_state_t;
endpackage

// [sts_pulse_if.sv]
`timescale 1ns/10ps
// Purpose: carries the alarm pulse request and timer state
// Assumes: one clock domain
// Notes: fire may repeat while busy; it restarts the timer
interface sts_pulse_if;
  logic fire;
  logic busy;
  modport timer (input fire, output busy);
  modport user  (output fire, input busy);
endinterface

// [sts_pulse_timer.sv]
`timescale 1ns/10ps
// Purpose: one second alarm pulse timer
// Assumes: CYC fits in the counter width
// Notes: busy stands for exactly CYC cycles after the last fire
module sts_pulse_timer #(
  parameter int unsigned CYC = sts_pkg::PULSE_CYC
) (
  input  wire logic  clk_in,
  input  wire logic  srst_in,
  sts_pulse_if.timer pulse
);
  logic [sts_pkg::CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_reg <= '0;
    end else if (pulse.fire) begin
      cnt_reg <= sts_pkg::CNT_W'(CYC);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign pulse.busy = (cnt_reg != '0);
endmodule

// [sts_supervisor.sv]
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
// Purpose: turns self-test results into reports, function blocking and alarm
// Assumes: monitored resources answer each scan request; zero-wait bus slave
// Notes: long counts are parameters so simulation can shorten them
module sts_supervisor #(
  parameter int unsigned PULSE_CYC  = sts_pkg::PULSE_CYC,
  parameter int unsigned PERIOD_CYC = sts_pkg::PERIOD_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic [31:0]      hrdata_out,
  output logic             hresp_out,
  output logic             mem_scan_out,
  input  wire logic        mem_valid_in,
  input  wire logic [7:0]  mem_word_in,
  input  wire logic        mem_last_in,
  input  wire logic        mem_all_in,
  input  wire logic [3:0]  mem_socket_in,
  input  wire logic [15:0] mem_ref_in,
  output logic             adc_start_out,
  input  wire logic        adc_done_in,
  output logic             master_offset_check_out,
  output logic             chan_scan_out,
  input  wire logic        ofs_valid_in,
  input  wire logic [7:0]  ofs_mv_in,
  input  wire logic        ofs_last_in,
  output logic             set_scan_out,
  input  wire logic        set_valid_in,
  input  wire logic [7:0]  set_a_in,
  input  wire logic [7:0]  set_b_in,
  input  wire logic        set_last_in,
  input  wire logic        p5_warn_in,
  input  wire logic        p5_fail_in,
  input  wire logic        p15_warn_in,
  input  wire logic        p15_fail_in,
  output logic             prot_en_out,
  output logic             ctrl_en_out,
  output logic             contacts_en_out,
  output logic             alarm_out,
  output logic             settings_apply_out,
  output logic             report_valid_out,
  output logic [2:0]       report_test_out,
  output logic [1:0]       report_code_out,
  output logic [3:0]       report_socket_out,
  output logic             irq_out
);
  sts_pkg::sts_state_t state_reg;
  logic [15:0]         sum_reg;
  logic [15:0]         sum_next;
  logic                mem_fail_reg;
  logic [3:0]          sock_reg;
  logic [31:0]         adc_cnt_reg;
  logic                adc_tmo;
  logic                adc_fail_reg;
  logic                adc_start_reg;
  logic [1:0]          mof_stat_reg;
  logic [1:0]          chan_stat_reg;
  logic [1:0]          chan_worst_reg;
  logic [1:0]          ofs_code;
  logic [1:0]          chan_next;
  logic                set_fail_reg;
  logic                p5_fail_reg;
  logic                p15_fail_reg;
  logic                run_pend_reg;
  logic                newset_pend_reg;
  logic                newset_arm_reg;
  logic                apply_reg;
  logic [31:0]         per_cnt_reg;
  logic                per_tick;
  logic                latched;
  logic [13:0]         stat_vec;
  logic [13:0]         rep_reg;
  logic                diff_found;
  logic [2:0]          diff_idx;
  logic                rep_valid_reg;
  logic [2:0]          rep_test_reg;
  logic [1:0]          rep_code_reg;
  logic                prot_en_reg;
  logic                ctrl_en_reg;
  logic                cont_en_reg;
  logic                alarm_reg;
  logic                cksum_bad;
  logic                set_bad;
  logic                acc;
  logic                wr_pend_reg;
  logic [7:0]          waddr_reg;
  logic [31:0]         hrdata_reg;
  logic [31:0]         rd_mux;
  logic                ctrl_wr;
  logic [7:0]          ist_reg;
  logic [7:0]          imsk_reg;
  logic [7:0]          ev;
  logic [7:0]          ist_clr;
  logic                irq_reg;
  sts_pulse_if         pulse ();

  sts_pulse_timer #(
    .CYC (PULSE_CYC)
  ) u_pulse (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .pulse   (pulse)
  );

  function automatic logic [1:0] ofs_class(input logic [7:0] mv);
    if (mv > sts_pkg::OFS_FAIL_MV) begin
      return sts_pkg::C_FAIL;
    end else if (mv > sts_pkg::OFS_WARN_MV) begin
      return sts_pkg::C_WARN;
    end
    return sts_pkg::C_NORM;
  endfunction

  // test sequencer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= sts_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        sts_pkg::ST_IDLE: begin
          if (run_pend_reg) begin
            state_reg <= sts_pkg::ST_MEM;
          end
        end
        sts_pkg::ST_MEM: begin
          if (mem_valid_in && mem_all_in) begin
            state_reg <= sts_pkg::ST_ADC;
          end
        end
        sts_pkg::ST_ADC: begin
          if (adc_done_in || adc_tmo) begin
            state_reg <= sts_pkg::ST_MOF;
          end
        end
        sts_pkg::ST_MOF: begin
          if (ofs_valid_in) begin
            state_reg <= sts_pkg::ST_CHAN;
          end
        end
        sts_pkg::ST_CHAN: begin
          if (ofs_valid_in && ofs_last_in) begin
            state_reg <= sts_pkg::ST_SET;
          end
        end
        sts_pkg::ST_SET: begin
          if (set_valid_in && set_last_in) begin
            state_reg <= sts_pkg::ST_DONE;
          end
        end
        sts_pkg::ST_DONE: begin
          state_reg <= sts_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= sts_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign mem_scan_out            = (state_reg == sts_pkg::ST_MEM);
  assign master_offset_check_out = (state_reg == sts_pkg::ST_MOF);
  assign chan_scan_out           = (state_reg == sts_pkg::ST_CHAN);
  assign set_scan_out            = (state_reg == sts_pkg::ST_SET);
  assign adc_start_out           = adc_start_reg;

  // power-up run pending, then periodic and software triggers
  assign per_tick = (per_cnt_reg == 32'(PERIOD_CYC - 1));
  always_ff @(posedge clk_in) begin
    if (srst_in || per_tick) begin
      per_cnt_reg <= '0;
    end else begin
      per_cnt_reg <= per_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      run_pend_reg <= 1'b1;
    end else if (ctrl_wr || per_tick) begin
      run_pend_reg <= 1'b1;
    end else if (state_reg == sts_pkg::ST_IDLE) begin
      run_pend_reg <= 1'b0;
    end
  end

  // new settings wait for a full run before they are applied
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      newset_pend_reg <= 1'b0;
      newset_arm_reg  <= 1'b0;
      apply_reg       <= 1'b0;
    end else begin
      apply_reg <= 1'b0;
      if (ctrl_wr && hwdata_in[sts_pkg::CTRL_NEWSET]) begin
        newset_pend_reg <= 1'b1;
      end else if (state_reg == sts_pkg::ST_IDLE && run_pend_reg) begin
        newset_pend_reg <= 1'b0;
      end
      if (state_reg == sts_pkg::ST_IDLE && run_pend_reg) begin
        newset_arm_reg <= newset_pend_reg;
      end else if (state_reg == sts_pkg::ST_DONE) begin
        newset_arm_reg <= 1'b0;
        apply_reg      <= newset_arm_reg && !latched;
      end
    end
  end
  assign settings_apply_out = apply_reg;

  // program memory checksum per chip
  assign sum_next  = sum_reg + 16'(mem_word_in);
  assign cksum_bad = mem_scan_out && mem_valid_in && mem_last_in && (sum_next != mem_ref_in);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sum_reg      <= sts_pkg::SUM_RESET;
      mem_fail_reg <= 1'b0;
      sock_reg     <= '0;
    end else if (mem_scan_out && mem_valid_in) begin
      sum_reg <= mem_last_in ? sts_pkg::SUM_RESET : sum_next;
      if (cksum_bad) begin
        mem_fail_reg <= 1'b1;
        if (!mem_fail_reg) begin
          sock_reg <= mem_socket_in;
        end
      end
    end else if (!mem_scan_out) begin
      sum_reg <= sts_pkg::SUM_RESET;
    end
  end

  // converter timing; a late done still counts as a failure
  assign adc_tmo = (state_reg == sts_pkg::ST_ADC) && !adc_done_in
                   && (adc_cnt_reg == 32'(sts_pkg::ADC_CYC - 1));
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      adc_cnt_reg   <= '0;
      adc_fail_reg  <= 1'b0;
      adc_start_reg <= 1'b0;
    end else begin
      adc_start_reg <= mem_scan_out && mem_valid_in && mem_all_in;
      adc_cnt_reg   <= (state_reg == sts_pkg::ST_ADC) ? adc_cnt_reg + 1'b1 : '0;
      if (adc_tmo) begin
        adc_fail_reg <= 1'b1;
      end
    end
  end

  // offsets: master is one sample, channels keep the worst of the scan
  assign ofs_code  = ofs_class(ofs_mv_in);
  assign chan_next = (ofs_code > chan_worst_reg) ? ofs_code : chan_worst_reg;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mof_stat_reg   <= sts_pkg::C_NORM;
      chan_stat_reg  <= sts_pkg::C_NORM;
      chan_worst_reg <= sts_pkg::C_NORM;
    end else begin
      if (master_offset_check_out && ofs_valid_in) begin
        mof_stat_reg <= ofs_code;
      end
      if (chan_scan_out && ofs_valid_in) begin
        chan_worst_reg <= ofs_last_in ? sts_pkg::C_NORM : chan_next;
        if (ofs_last_in) begin
          chan_stat_reg <= chan_next;
        end
      end
    end
  end

  // offset failures pulse the alarm and latch nothing
  assign pulse.fire = ofs_valid_in && ofs_code == sts_pkg::C_FAIL && master_offset_check_out
                      || chan_scan_out && ofs_valid_in && ofs_last_in && chan_next == sts_pkg::C_FAIL;

  // settings images and supplies
  assign set_bad = set_scan_out && set_valid_in && (set_a_in != set_b_in);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      set_fail_reg <= 1'b0;
      p5_fail_reg  <= 1'b0;
      p15_fail_reg <= 1'b0;
    end else begin
      if (set_bad) begin
        set_fail_reg <= 1'b1;
      end
      if (p5_fail_in) begin
        p5_fail_reg <= 1'b1;
      end
      if (p15_fail_in) begin
        p15_fail_reg <= 1'b1;
      end
    end
  end

  // only reset clears a latched failure
  assign latched = mem_fail_reg || adc_fail_reg || set_fail_reg || p5_fail_reg || p15_fail_reg;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prot_en_reg <= 1'b0;
      ctrl_en_reg <= 1'b0;
      cont_en_reg <= 1'b0;
      alarm_reg   <= 1'b0;
    end else begin
      prot_en_reg <= !latched;
      ctrl_en_reg <= !(mem_fail_reg || set_fail_reg || p5_fail_reg);
      cont_en_reg <= !p5_fail_reg;
      alarm_reg   <= latched || pulse.busy;
    end
  end
  assign prot_en_out     = prot_en_reg;
  assign ctrl_en_out     = ctrl_en_reg;
  assign contacts_en_out = cont_en_reg;
  assign alarm_out       = alarm_reg;

  // status of each test; supplies show warnings live
  always_comb begin
    stat_vec                          = '0;
    stat_vec[2*sts_pkg::T_MEM +: 2]   = mem_fail_reg ? sts_pkg::C_FAIL : sts_pkg::C_NORM;
    stat_vec[2*sts_pkg::T_ADC +: 2]   = adc_fail_reg ? sts_pkg::C_FAIL : sts_pkg::C_NORM;
    stat_vec[2*sts_pkg::T_MOF +: 2]   = mof_stat_reg;
    stat_vec[2*sts_pkg::T_CHAN +: 2]  = chan_stat_reg;
    stat_vec[2*sts_pkg::T_SET +: 2]   = set_fail_reg ? sts_pkg::C_FAIL : sts_pkg::C_NORM;
    stat_vec[2*sts_pkg::T_P5 +: 2]    = p5_fail_reg ? sts_pkg::C_FAIL
                                        : (p5_warn_in ? sts_pkg::C_WARN : sts_pkg::C_NORM);
    stat_vec[2*sts_pkg::T_P15 +: 2]   = p15_fail_reg ? sts_pkg::C_FAIL
                                        : (p15_warn_in ? sts_pkg::C_WARN : sts_pkg::C_NORM);
  end

  // one report per cycle, lowest test first; none is lost
  always_comb begin
    diff_found = 1'b0;
    diff_idx   = '0;
    for (int i = sts_pkg::NTEST - 1; i >= 0; i--) begin
      if (stat_vec[2*i +: 2] != rep_reg[2*i +: 2]) begin
        diff_found = 1'b1;
        diff_idx   = 3'(i);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rep_reg       <= '0;
      rep_valid_reg <= 1'b0;
      rep_test_reg  <= '0;
      rep_code_reg  <= sts_pkg::C_NORM;
    end else begin
      rep_valid_reg <= diff_found;
      if (diff_found) begin
        rep_reg[2*diff_idx +: 2] <= stat_vec[2*diff_idx +: 2];
        rep_test_reg             <= diff_idx;
        rep_code_reg             <= stat_vec[2*diff_idx +: 2];
      end
    end
  end
  assign report_valid_out  = rep_valid_reg;
  assign report_test_out   = rep_test_reg;
  assign report_code_out   = rep_code_reg;
  assign report_socket_out = sock_reg;

  // bus slave, zero wait states
  assign acc     = hsel_in && htrans_in[1] && hready_in;
  assign ctrl_wr = wr_pend_reg && (waddr_reg == sts_pkg::ADDR_CTRL);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_pend_reg <= 1'b0;
      waddr_reg   <= '0;
    end else if (hready_in) begin
      wr_pend_reg <= acc && hwrite_in && (hsize_in == 3'h2);
      waddr_reg   <= haddr_in[7:0];
    end
  end

  always_comb begin
    rd_mux = '0;
    case (haddr_in[7:0])
      sts_pkg::ADDR_STAT: begin
        rd_mux[13:0]               = stat_vec;
        rd_mux[sts_pkg::STAT_BUSY]  = (state_reg != sts_pkg::ST_IDLE);
        rd_mux[sts_pkg::STAT_PROT]  = prot_en_reg;
        rd_mux[sts_pkg::STAT_CTRL]  = ctrl_en_reg;
        rd_mux[sts_pkg::STAT_ALARM] = alarm_reg;
        rd_mux[sts_pkg::STAT_CONT]  = cont_en_reg;
      end
      sts_pkg::ADDR_SOCK: rd_mux[3:0] = sock_reg;
      sts_pkg::ADDR_IST:  rd_mux[7:0] = ist_reg;
      sts_pkg::ADDR_IMSK: rd_mux[7:0] = imsk_reg;
      default:            rd_mux      = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hrdata_reg <= '0;
    end else if (acc && !hwrite_in) begin
      hrdata_reg <= rd_mux;
    end
  end
  assign hrdata_out    = hrdata_reg;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // sticky events, set beats write-one-to-clear
  always_comb begin
    ev                   = '0;
    ev[diff_idx]         = diff_found;
    ev[sts_pkg::IST_DONE] = (state_reg == sts_pkg::ST_DONE);
  end
  assign ist_clr = (wr_pend_reg && waddr_reg == sts_pkg::ADDR_IST) ? hwdata_in[7:0] : 8'h00;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ist_reg  <= '0;
      imsk_reg <= sts_pkg::IMSK_RESET;
      irq_reg  <= 1'b0;
    end else begin
      ist_reg <= (ist_reg & ~ist_clr) | ev;
      if (wr_pend_reg && waddr_reg == sts_pkg::ADDR_IMSK) begin
        imsk_reg <= hwdata_in[7:0];
      end
      irq_reg <= |(ist_reg & imsk_reg);
    end
  end
  assign irq_out = irq_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_ofs_fail;
    master_offset_check_out && ofs_valid_in && ofs_mv_in > sts_pkg::OFS_FAIL_MV;
  endsequence
  sequence s_pulse_on;
    pulse.busy ##1 alarm_out;
  endsequence

  AST_CKSUM: assert property (cksum_bad |=> mem_fail_reg && stat_vec[1:0] == sts_pkg::C_FAIL)
    else $error("checksum mismatch not flagged");
  AST_MEM_OFF: assert property (cksum_bad |=> ##1 !prot_en_out && !ctrl_en_out && alarm_out)
    else $error("memory failure left functions on");
  AST_SOCKET: assert property (cksum_bad && !mem_fail_reg |=> report_socket_out == $past(mem_socket_in))
    else $error("socket not kept");
  AST_ADC_TMO: assert property (adc_tmo |=> adc_fail_reg && state_reg == sts_pkg::ST_MOF)
    else $error("conversion timeout missed");
  AST_ADC_ONLY: assert property (adc_fail_reg && !mem_fail_reg && !set_fail_reg && !p5_fail_reg
                                 |=> !prot_en_out && ctrl_en_out && alarm_out)
    else $error("converter failure action wrong");
  AST_MOF_WARN: assert property (master_offset_check_out && ofs_valid_in && ofs_mv_in > sts_pkg::OFS_WARN_MV
                                 && ofs_mv_in <= sts_pkg::OFS_FAIL_MV |=> mof_stat_reg == sts_pkg::C_WARN)
    else $error("master offset warning missed");
  AST_MOF_PULSE: assert property (s_ofs_fail |=> s_pulse_on)
    else $error("master offset pulse missing");
  AST_SET_OFF: assert property (set_bad |=> ##1 !prot_en_out && !ctrl_en_out && alarm_out)
    else $error("settings mismatch left functions on");
  AST_SET_LATCH: assert property (set_fail_reg |=> set_fail_reg [*8])
    else $error("settings failure not latched");
  AST_QUIET: assert property (!latched && !pulse.busy |=> !alarm_out)
    else $error("alarm without failure");
  AST_REPORT: assert property ($changed(stat_vec) |-> ##[1:8] report_valid_out)
    else $error("status change not reported");
  AST_P5: assert property (p5_fail_in |=> ##1 !contacts_en_out && !ctrl_en_out)
    else $error("contacts not blocked");
  AST_P15: assert property (p15_fail_in && !latched |=> ##1 !prot_en_out && ctrl_en_out)
    else $error("15 V failure action wrong");
endmodule

// [sts_res_model.sv]
// Purpose: model of memories, converter, offsets, settings images
// Assumes: one sample every other cycle while a step is selected
// Notes: idle data lines invert so stale values never look valid
`timescale 1ns/10ps
module sts_res_model (
  input  wire logic        clk_in, mem_scan_in, adc_start_in, mof_in, chan_in, set_in, mem_bad_in,
  input  wire logic [7:0]  mof_mv_in,
  output logic             mem_valid_out, mem_last_out, adc_done_out, ofs_valid_out, ofs_last_out,
  output logic             set_valid_out, set_last_out,
  output logic [7:0]       mem_word_out, ofs_mv_out, set_a_out, set_b_out,
  output logic [15:0]      mem_ref_out
);
  always @(posedge clk_in) begin
    mem_valid_out <= mem_scan_in && !mem_valid_out;
    mem_last_out  <= mem_scan_in;
    mem_word_out  <= mem_scan_in ? 8'h01 : ~mem_word_out;
    mem_ref_out   <= mem_bad_in ? 16'h0002 : 16'h0001;
    adc_done_out  <= adc_start_in;
    ofs_valid_out <= (mof_in || chan_in) && !ofs_valid_out;
    ofs_last_out  <= chan_in;
    ofs_mv_out    <= mof_in ? mof_mv_in : (chan_in ? 8'h0a : ~ofs_mv_out);
    set_valid_out <= set_in && !set_valid_out;
    set_last_out  <= set_in;
    set_a_out     <= set_in ? 8'h33 : ~set_a_out;
    set_b_out     <= set_in ? 8'h33 : ~set_b_out;
  end
endmodule

// [self_test_supervisor_tb.sv]
// Purpose: self-checking bench of the supervisor
// Assumes: pulse shortened to 20 cycles
// Notes: supply warnings stay low
`timescale 1ns/10ps
module self_test_supervisor_tb;
  logic clk_in, srst_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out, mem_bad;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, d;
  logic [1:0] htrans_in, report_code_out;
  logic [2:0] hsize_in, report_test_out;
  logic mem_scan_out, mem_valid_in, mem_last_in, mem_all_in, adc_start_out, adc_done_in;
  logic master_offset_check_out, chan_scan_out, ofs_valid_in, ofs_last_in, set_scan_out, set_valid_in;
  logic set_last_in, p5_warn_in, p5_fail_in, p15_warn_in, p15_fail_in, prot_en_out, ctrl_en_out;
  logic contacts_en_out, alarm_out, settings_apply_out, report_valid_out, irq_out;
  logic [7:0] mem_word_in, ofs_mv_in, set_a_in, set_b_in, mof_mv;
  logic [3:0] mem_socket_in, report_socket_out;
  logic [15:0] mem_ref_in;
  logic [1:0] rep [8];
  int fail_count = 0;
  int n_checks = 0;
  int n;
  int n_apply = 0;
  always @(posedge clk_in) if (settings_apply_out === 1'b1) n_apply++;
  assign hready_in = hreadyout_out;
  assign mem_all_in = mem_last_in;
  assign mem_socket_in = 4'h5;
  sts_supervisor #(.PULSE_CYC(20), .PERIOD_CYC(20000)) i_sts_supervisor (.*);
  sts_res_model i_sts_res_model (.clk_in(clk_in), .mem_scan_in(mem_scan_out), .adc_start_in(adc_start_out),
    .mof_in(master_offset_check_out), .chan_in(chan_scan_out), .set_in(set_scan_out), .mem_bad_in(mem_bad),
    .mof_mv_in(mof_mv), .mem_valid_out(mem_valid_in), .mem_last_out(mem_last_in), .adc_done_out(adc_done_in),
    .ofs_valid_out(ofs_valid_in), .ofs_last_out(ofs_last_in), .set_valid_out(set_valid_in),
    .set_last_out(set_last_in), .mem_word_out(mem_word_in), .ofs_mv_out(ofs_mv_in), .set_a_out(set_a_in),
    .set_b_out(set_b_in), .mem_ref_out(mem_ref_in));
  always @(posedge clk_in) if (report_valid_out === 1'b1) rep[report_test_out] <= report_code_out;
  initial begin
    clk_in = 0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one AHB-Lite single word transfer, called just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel_in <= 1; htrans_in <= 2'h2; haddr_in <= {24'h0, a}; hwrite_in <= w; hsize_in <= 3'h2;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    hsel_in <= 0; htrans_in <= 2'h0; hwdata_in <= wd;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    d = hrdata_out;
  endtask
  task automatic wait_done;
    do bus(0, sts_pkg::ADDR_IST, 0); while (d[sts_pkg::IST_DONE] !== 1'b1);
  endtask
  task automatic run;
    bus(1, sts_pkg::ADDR_IST, 32'hff);
    bus(1, sts_pkg::ADDR_CTRL, 32'h2);
  endtask
  task automatic t_power;
    wait_done;
    bus(0, sts_pkg::ADDR_STAT, 0);
    chk("status", d, 32'h0016_0000);
    chk("no apply", n_apply, 0);
    chk("hresp", hresp_out, 0);
    bus(0, 8'h40, 0);
    chk("unmapped", d, 0);
  endtask
  task automatic t_mof;
    mof_mv <= 8'h50;
    run;
    do @(posedge clk_in); while (alarm_out !== 1'b1);
    chk("prot", {ctrl_en_out, prot_en_out}, 2'h3);
    for (n = 0; alarm_out === 1'b1; n++) @(posedge clk_in);
    chk("pulse", n, 20);
    wait_done;
    chk("mof fail", rep[sts_pkg::T_MOF], sts_pkg::C_FAIL);
  endtask
  task automatic t_warn;
    mof_mv <= 8'h3c;
    bus(1, sts_pkg::ADDR_IMSK, 32'h80);
    bus(1, sts_pkg::ADDR_IST, 32'hff);
    bus(1, sts_pkg::ADDR_CTRL, 32'h1);
    wait_done;
    repeat (2) @(posedge clk_in);
    chk("apply", n_apply, 1);
    chk("warn", rep[sts_pkg::T_MOF], sts_pkg::C_WARN);
    chk("quiet", {alarm_out, ctrl_en_out, prot_en_out}, 3'h3);
    chk("irq", irq_out, 1);
    bus(1, sts_pkg::ADDR_IST, 32'hff);
    repeat (2) @(posedge clk_in);
    chk("irq clr", irq_out, 0);
  endtask
  task automatic t_fail;
    p15_fail_in <= 1;
    repeat (30) @(posedge clk_in);
    chk("p15", {alarm_out, ctrl_en_out, prot_en_out}, 3'h6);
    mem_bad <= 1;
    run;
    wait_done;
    chk("mem", {alarm_out, ctrl_en_out}, 2'h2);
    chk("mem code", rep[sts_pkg::T_MEM], sts_pkg::C_FAIL);
    bus(0, sts_pkg::ADDR_SOCK, 0);
    chk("socket", d[3:0], 4'h5);
    p5_fail_in <= 1;
    repeat (3) @(posedge clk_in);
    chk("contacts", contacts_en_out, 0);
    chk("apply latched", n_apply, 1);
  endtask
  initial begin
    {hsel_in, hwrite_in, htrans_in, hsize_in, haddr_in, hwdata_in} = 0;
    {p5_warn_in, p5_fail_in, p15_warn_in, p15_fail_in, mem_bad} = 0;
    mof_mv = 8'h0a;
    srst_in = 1;
    repeat (8) @(posedge clk_in);
    srst_in <= 0;
    @(posedge clk_in);
    t_power;
    t_mof;
    t_warn;
    t_fail;
    results;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    results;
  end
endmodule
